/* File: core/network_time_rtc.sv */
// network real-time clock: controlled-frequency counter, offset copy, 8 kHz tick
//
// Contract
// RULE1 - nanoseconds field is 32 bits and counts one second then returns to zero
// RULE2 - seconds field is 48 bits and sits beside nanoseconds
// RULE3 - seconds wrap to zero only from all ones
// RULE4 - increment resolution is one two-to-the-twentieth of a nanosecond
// RULE5 - 20-bit sub-nanoseconds field sits below nanoseconds as one accumulator
// RULE6 - all counting runs on the single reference clock
// RULE7 - 26-bit increment: top six bits to nanoseconds, low twenty to fraction
// RULE8 - increment is added to the counter every reference clock cycle
// RULE9 - counter starts at zero after reset and advances by the programmed increment
// RULE10 - increment value 0x800000 means exactly 8 ns per cycle
// RULE11 - increments up to just below 64 ns are supported
// RULE12 - nanoseconds offset added each cycle gives the synchronised nanoseconds output
// RULE13 - seconds step on synchronised one-second carry and take the seconds offset
// RULE14 - software steps the clock through seconds and nanoseconds offsets
// RULE15 - 8 kHz clock output derives from synchronised nanoseconds
// RULE16 - timestamp capture samples controlled-frequency nanoseconds, not synchronised
// RULE17 - carry past one billion subtracts one billion and adds a second same cycle
// RULE18 - written settings act from the next cycle and hold until rewritten
`timescale 1ns/1ps
module network_time_rtc
  import rtc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic incWrite,
  input wire logic [INC_W-1:0] incValue,
  input wire logic offsetWrite,
  input rtcTime_t offsetValue,
  input wire logic captureStrobe,
  output rtcTime_t syncTime,
  output rtcTime_t cfTime,
  output logic [INC_W-1:0] incSetting,
  output rtcTime_t offsetSetting,
  output logic [NS_W-1:0] capturedNs,
  output logic captureValid,
  output logic network_tick_8khz
);

  // ==========================================================================
  // state
  logic [INC_W-1:0] inc_q, inc_d;
  rtcTime_t offset_q, offset_d;
  rtcTime_t cf_q, cf_d; // see RULE2
  logic [SUBNS_W-1:0] sub_q, sub_d;
  rtcTime_t sync_q, sync_d;
  rtcTime_t syncSum;
  logic tick_q, tick_d;
  logic [NS_W-1:0] cap_q, cap_d;
  logic capValid_q, capValid_d;

  // ==========================================================================
  // helpers
  function automatic logic [ACC_W:0] accAdd(input logic [NS_W-1:0] ns,
                                           input logic [SUBNS_W-1:0] sub,
                                           input logic [INC_W-1:0] inc);
    logic [ACC_W:0] acc;
    acc = {1'b0, ns, sub} + {{(ACC_W + 1 - INC_W){1'b0}}, inc}; // see RULE7
    return acc;
  endfunction : accAdd

  function automatic logic tickLevel(input logic [NS_W-1:0] ns);
    logic [NS_W-1:0] phase;
    phase = ns % TICK_PERIOD_NS;
    return (phase < TICK_HALF_NS);
  endfunction : tickLevel

  // ==========================================================================
  // settings written by software
  always_comb
  begin
    inc_d = inc_q;
    offset_d = offset_q;
    if (incWrite)
    begin
      inc_d = incValue; // see RULE18
    end
    if (offsetWrite)
    begin
      offset_d = offsetValue; // see RULE14
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      inc_q <= INC_RESET; // see RULE10
      offset_q <= TIME_RESET;
    end
    else
    begin
      inc_q <= inc_d;
      offset_q <= offset_d;
    end
  end

  // ==========================================================================
  // controlled-frequency counter
  logic [ACC_W:0] accNext;
  logic [NS_W:0] cfNsRaw;
  logic cfWrap;

  always_comb
  begin
    // fraction extends nanoseconds below bit 0, units of 2^-20 ns
    accNext = accAdd(cf_q.ns, sub_q, inc_q); // see RULE4
    cfNsRaw = accNext[ACC_W:SUBNS_W];
    cfWrap = (cfNsRaw >= {1'b0, NS_PER_SEC}); // see RULE1
    sub_d = accNext[SUBNS_W-1:0]; // see RULE5
    cf_d.ns = cfWrap ? NS_W'(cfNsRaw - {1'b0, NS_PER_SEC}) : cfNsRaw[NS_W-1:0]; // see RULE17
    // seconds roll over naturally from all ones only
    cf_d.sec = cf_q.sec + (cfWrap ? SEC_ONE : '0); // see RULE3
  end

  // every rising edge of the one reference clock advances the counter
  always_ff @(posedge clk or negedge rst_n) // see RULE6
  begin
    if (!rst_n)
    begin
      cf_q <= TIME_RESET; // see RULE9
      sub_q <= SUBNS_RESET;
    end
    else
    begin
      cf_q <= cf_d; // see RULE8
      sub_q <= sub_d;
    end
  end

  // ==========================================================================
  // synchronised copy: counter plus offset
  rtc_time_add offsetAdder (
    .a(cf_q),
    .b(offset_q),
    .sum(syncSum)
  );

  always_comb
  begin
    sync_d = syncSum; // see RULE12
    tick_d = tickLevel(sync_q.ns); // see RULE15
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_q <= TIME_RESET;
      tick_q <= 1'b0;
    end
    else
    begin
      sync_q <= sync_d; // see RULE13
      tick_q <= tick_d;
    end
  end

  // ==========================================================================
  // timestamp capture from the smooth counter
  always_comb
  begin
    cap_d = cap_q;
    capValid_d = 1'b0;
    if (captureStrobe)
    begin
      cap_d = cf_q.ns; // see RULE16
      capValid_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cap_q <= '0;
      capValid_q <= 1'b0;
    end
    else
    begin
      cap_q <= cap_d;
      capValid_q <= capValid_d;
    end
  end

  // ==========================================================================
  // outputs
  assign syncTime = sync_q;
  assign cfTime = cf_q;
  assign incSetting = inc_q;
  assign offsetSetting = offset_q;
  assign capturedNs = cap_q;
  assign captureValid = capValid_q;
  assign network_tick_8khz = tick_q;

  // ==========================================================================
  // checks
  logic afterReset_q;
  logic [ACC_W:0] accPrev_q;
  logic [NS_W:0] syncRaw_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      afterReset_q <= 1'b1;
      accPrev_q <= '0;
      syncRaw_q <= '0;
    end
    else
    begin
      afterReset_q <= 1'b0;
      accPrev_q <= accNext;
      syncRaw_q <= {1'b0, cf_q.ns} + {1'b0, offset_q.ns};
    end
  end

  sequence incWritten;
    incWrite ##1 !incWrite;
  endsequence

  sequence secondCarry;
    (cfNsRaw >= {1'b0, NS_PER_SEC}) ##1 1'b1;
  endsequence

  // nanoseconds never reach one second
  cfNsRange_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE1
    cf_q.ns < NS_PER_SEC && sync_q.ns < NS_PER_SEC)
    else $error("nanoseconds field reached one second");

  // counter starts at zero straight after reset
  resetZero_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE9
    afterReset_q |-> (cf_q == TIME_RESET && sub_q == SUBNS_RESET))
    else $error("counter not zero after reset");

  // accumulator advances by the held increment
  cfAdvance_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE8
    (!afterReset_q && !$past(cfWrap)) |->
      ({1'b0, cf_q.ns, sub_q} == accPrev_q)
      && (accPrev_q == {1'b0, $past(cf_q.ns), $past(sub_q)} + {27'h0000000, $past(inc_q)}))
    else $error("counter did not add increment");

  // one billion wraps back and adds a second at once
  cfWrap_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE17
    secondCarry |-> (cf_q.sec == $past(cf_q.sec) + SEC_ONE)
      && ({1'b0, cf_q.ns} == $past(cfNsRaw) - {1'b0, NS_PER_SEC}))
    else $error("nanosecond carry lost");

  // seconds fall only out of all ones
  secWrap_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE3
    (cf_q.sec < $past(cf_q.sec)) |-> ($past(cf_q.sec) == SEC_MAX && cf_q.sec == '0))
    else $error("seconds wrapped early");

  // increment write seen one cycle later and then held
  incLoad_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE18
    incWritten |-> (inc_q == $past(incValue)) ##1 $stable(inc_q))
    else $error("increment not loaded or not held");

  // offset write seen one cycle later
  offsetLoad_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE14
    offsetWrite |=> (offset_q == $past(offsetValue)))
    else $error("offset not loaded");

  // synchronised nanoseconds equal counter plus offset
  syncSum_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE12
    !afterReset_q |-> (syncRaw_q >= {1'b0, NS_PER_SEC}
      ? ({1'b0, sync_q.ns} == syncRaw_q - {1'b0, NS_PER_SEC})
      : ({1'b0, sync_q.ns} == syncRaw_q)))
    else $error("synchronised nanoseconds wrong");

  // synchronised seconds take the offset and the carry
  syncSec_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE13
    !afterReset_q |-> (sync_q.sec == $past(cf_q.sec) + $past(offset_q.sec)
      + ((syncRaw_q >= {1'b0, NS_PER_SEC}) ? SEC_ONE : '0)))
    else $error("synchronised seconds wrong");

  // tick follows phase of synchronised time
  tickPhase_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE15
    $rose(tick_q) |-> (($past(sync_q.ns) % TICK_PERIOD_NS) < TICK_HALF_NS))
    else $error("tick rose at wrong phase");

  // capture takes the smooth counter
  captureCf_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE16
    captureStrobe |=> (capValid_q && cap_q == $past(cf_q.ns)))
    else $error("capture did not sample counter");

  // nominal setting gives exactly eight nanoseconds
  nominalStep_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE10
    (inc_q == INC_RESET && !$past(cfWrap) && !afterReset_q && $stable(inc_q))
      |-> (cf_q.ns - $past(cf_q.ns) == 32'h00000008 && sub_q == $past(sub_q)))
    else $error("nominal increment not eight ns");

  // fraction field keeps low twenty increment bits
  fracAlign_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE7
    !afterReset_q |-> (sub_q == SUBNS_W'($past(sub_q) + $past(inc_q[SUBNS_W-1:0]))))
    else $error("fraction misaligned");

  // largest increment stays below 64 ns
  maxStep_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE11
    (!$past(cfWrap) && !afterReset_q)
      |-> (({cf_q.ns, sub_q} - {$past(cf_q.ns), $past(sub_q)}) < {32'h00000040, 20'h00000}))
    else $error("step of 64 ns or more");

endmodule : network_time_rtc

/* File: core/rtc_time_add.sv */
// combinational sum of two time records with nanosecond wrap into seconds
`timescale 1ns/1ps
module rtc_time_add
  import rtc_pkg::*;
(
  input rtcTime_t a,
  input rtcTime_t b,
  output rtcTime_t sum
);

  logic [NS_W:0] nsSum;
  logic nsWrap;

  // ==========================================================================
  // nanosecond sum and carry into seconds
  always_comb
  begin
    nsSum = {1'b0, a.ns} + {1'b0, b.ns};
    nsWrap = (nsSum >= {1'b0, NS_PER_SEC});
    sum.ns = nsWrap ? NS_W'(nsSum - {1'b0, NS_PER_SEC}) : nsSum[NS_W-1:0]; // see RULE17
    sum.sec = a.sec + b.sec + (nsWrap ? SEC_ONE : '0); // see RULE13
  end

endmodule : rtc_time_add

/* File: dv/network_time_rtc_bench.sv */
// testbench: self-checking scenarios for the network real-time clock
`timescale 1ns/1ps
module network_time_rtc_bench
  import rtc_pkg::*;
;
  logic clk;
  logic rst_n;
  logic incWrite;
  logic [INC_W-1:0] incValue;
  logic offsetWrite;
  rtcTime_t offsetValue;
  logic captureStrobe;
  rtcTime_t syncTime;
  rtcTime_t cfTime;
  logic [INC_W-1:0] incSetting;
  rtcTime_t offsetSetting;
  logic [NS_W-1:0] capturedNs;
  logic captureValid;
  logic tick;
  int fails;
  int nChecks;
  rtcTime_t mCf;
  logic [SUBNS_W-1:0] mFrac;
  rtcTime_t mSync;
  logic [INC_W-1:0] mInc;
  rtcTime_t mOff;
  logic [NS_W-1:0] mCap;
  logic mValid;
  logic mTick;

  network_time_rtc dut (
    .clk(clk),
    .rst_n(rst_n),
    .incWrite(incWrite),
    .incValue(incValue),
    .offsetWrite(offsetWrite),
    .offsetValue(offsetValue),
    .captureStrobe(captureStrobe),
    .syncTime(syncTime),
    .cfTime(cfTime),
    .incSetting(incSetting),
    .offsetSetting(offsetSetting),
    .capturedNs(capturedNs),
    .captureValid(captureValid),
    .network_tick_8khz(tick)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========================================================================
  // reference model
  function automatic rtcTime_t addTime(input rtcTime_t a, input rtcTime_t b);
    rtcTime_t s;
    s.ns = a.ns + b.ns;
    s.sec = a.sec + b.sec;
    if (s.ns >= NS_PER_SEC)
    begin
      s.ns = s.ns - NS_PER_SEC;
      s.sec = s.sec + SEC_ONE;
    end
    return s;
  endfunction : addTime

  always @(posedge clk or negedge rst_n)
  begin : refModel
    logic [ACC_W-1:0] acc;
    rtcTime_t raw;
    if (!rst_n)
    begin
      mCf <= TIME_RESET;
      mFrac <= SUBNS_RESET;
      mSync <= TIME_RESET;
      mInc <= INC_RESET;
      mOff <= TIME_RESET;
      mCap <= 32'h00000000;
      mValid <= 1'b0;
      mTick <= 1'b0;
    end
    else
    begin
      acc = {mCf.ns, mFrac} + {26'h0000000, mInc};
      raw.sec = mCf.sec;
      raw.ns = acc[ACC_W-1:SUBNS_W];
      mCf <= addTime(raw, TIME_RESET);
      mFrac <= acc[SUBNS_W-1:0];
      mSync <= addTime(mCf, mOff);
      if (incWrite)
        mInc <= incValue;
      if (offsetWrite)
        mOff <= offsetValue;
      if (captureStrobe)
        mCap <= mCf.ns;
      mValid <= captureStrobe;
      mTick <= (mSync.ns % TICK_PERIOD_NS) < TICK_HALF_NS;
    end
  end

  // ==========================================================================
  // checking and driving
  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    nChecks++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic compare_all;
    check(cfTime, mCf);
    check(syncTime, mSync);
    check({54'h0, incSetting}, {54'h0, mInc});
    check(offsetSetting, mOff);
    check({48'h0, capturedNs}, {48'h0, mCap});
    check({79'h0, captureValid}, {79'h0, mValid});
    check({79'h0, tick}, {79'h0, mTick});
  endtask : compare_all

  task automatic cycle(input logic iw, input logic [INC_W-1:0] iv, input logic ow,
                       input rtcTime_t ov, input logic cs);
    @(negedge clk);
    compare_all();
    incWrite = iw;
    incValue = iv;
    offsetWrite = ow;
    offsetValue = ov;
    captureStrobe = cs;
  endtask : cycle

  task automatic step(input int n);
    repeat (n) cycle(1'b0, 26'h0000000, 1'b0, TIME_RESET, 1'b0);
  endtask : step

  task automatic set_offset(input logic [SEC_W-1:0] s, input logic [NS_W-1:0] n);
    cycle(1'b0, 26'h0000000, 1'b1, '{sec: s, ns: n}, 1'b0);
    step(14);
  endtask : set_offset

  // ==========================================================================
  // scenarios
  task automatic nominal_run;
    step(4);
    check({48'h0, cfTime.ns}, {48'h0, 32'h00000020});
  endtask : nominal_run

  task automatic increment_change;
    cycle(1'b1, 26'h0180000, 1'b0, TIME_RESET, 1'b0);
    step(3);
    cycle(1'b1, 26'h3ffffff, 1'b0, TIME_RESET, 1'b0);
    cycle(1'b1, 26'h00c0001, 1'b0, TIME_RESET, 1'b0);
    step(3);
    cycle(1'b1, INC_RESET, 1'b0, TIME_RESET, 1'b0);
    step(2);
  endtask : increment_change

  task automatic offset_carry;
    set_offset(48'h000000000005, NS_PER_SEC - 32'h00000040 - mCf.ns);
    set_offset(SEC_MAX, NS_PER_SEC - 32'h00000040 - mCf.ns);
    check({32'h0, syncTime.sec}, 80'h0);
  endtask : offset_carry

  task automatic capture_pair;
    set_offset(48'h000000000002, 32'h12345678);
    cycle(1'b0, 26'h0000000, 1'b0, TIME_RESET, 1'b1);
    cycle(1'b0, 26'h0000000, 1'b0, TIME_RESET, 1'b1);
    step(3);
  endtask : capture_pair

  task automatic tick_edges;
    set_offset(48'h000000000000, TICK_HALF_NS - 32'h00000040 - mCf.ns);
    set_offset(48'h000000000000, TICK_PERIOD_NS - 32'h00000040 - mCf.ns);
  endtask : tick_edges

  task automatic mid_reset;
    @(negedge clk);
    rst_n = 1'b0;
    step(2);
    rst_n = 1'b1;
    step(3);
  endtask : mid_reset

  task automatic test_done;
    if (fails == 0 && nChecks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  initial
  begin
    #50000;
    fails++;
    test_done();
  end

  initial
  begin
    fails = 0;
    nChecks = 0;
    rst_n = 1'b0;
    incWrite = 1'b0;
    incValue = 26'h0000000;
    offsetWrite = 1'b0;
    offsetValue = TIME_RESET;
    captureStrobe = 1'b0;
    repeat (20) @(negedge clk);
    check(cfTime, TIME_RESET);
    check({54'h0, incSetting}, {54'h0, INC_RESET});
    rst_n = 1'b1;
    nominal_run();
    increment_change();
    offset_carry();
    capture_pair();
    tick_edges();
    mid_reset();
    test_done();
  end
endmodule : network_time_rtc_bench

/* File: inc/rtc_pkg.sv */
// package: field widths, constants and time record type of the network clock
package rtc_pkg;

  // ==========================================================================
  // field widths
  localparam int unsigned NS_W = 32;
  localparam int unsigned SUBNS_W = 20;
  localparam int unsigned SEC_W = 48;
  localparam int unsigned INC_W = 26;
  localparam int unsigned ACC_W = NS_W + SUBNS_W;

  // ==========================================================================
  // field positions of the increment word
  localparam int unsigned INC_NS_LSB = 20;
  localparam int unsigned INC_NS_W = INC_W - INC_NS_LSB;

  // ==========================================================================
  // counting constants
  localparam logic [NS_W-1:0] NS_PER_SEC = 32'h3b9aca00;
  localparam logic [SEC_W-1:0] SEC_ONE = 48'h000000000001;
  localparam logic [SEC_W-1:0] SEC_MAX = 48'hffffffffffff;

  // ==========================================================================
  // reset values
  localparam logic [INC_W-1:0] INC_RESET = 26'h0800000;
  localparam logic [SUBNS_W-1:0] SUBNS_RESET = 20'h00000;

  // ==========================================================================
  // derived clock output
  localparam logic [NS_W-1:0] TICK_FREQ_HZ = 32'h00001f40;
  localparam logic [NS_W-1:0] TICK_PERIOD_NS = NS_PER_SEC / TICK_FREQ_HZ;
  localparam logic [NS_W-1:0] TICK_HALF_NS = TICK_PERIOD_NS / 32'h00000002;

  // ==========================================================================
  // time record: seconds above nanoseconds
  typedef struct packed {
    logic [SEC_W-1:0] sec;
    logic [NS_W-1:0] ns;
  } rtcTime_t;

  localparam rtcTime_t TIME_RESET = '{sec: 48'h000000000000, ns: 32'h00000000};

endpackage : rtc_pkg
